// [tsc_pkg.sv]
/*
  Constants and types shared by the touch-screen converter control logic.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package tsc_pkg;

  localparam int          CTRL_W       = 8;
  localparam int          RES_W        = 12;
  localparam int          RES8_W       = 8;
  localparam int          BIT_SEL_HI   = 6;
  localparam int          BIT_SEL_LO   = 4;
  localparam int          BIT_MODE     = 3;
  localparam int          BIT_REF      = 2;
  localparam int          BIT_PD_HI    = 1;
  localparam int          BIT_PD_LO    = 0;
  localparam logic [2:0]  SEL_XPOS     = 3'h5;
  localparam logic [2:0]  SEL_YPOS     = 3'h1;
  localparam logic [1:0]  PD_ALWAYS_ON = 2'h3;
  localparam logic [1:0]  PD_SLEEP_NOIRQ = 2'h1;
  localparam logic [1:0]  PD_SLEEP_IRQ = 2'h0;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [3:0]  CNT_HUNT     = 4'h0;
  localparam logic [3:0]  CNT_FIRST    = 4'h1;
  localparam logic [3:0]  CNT_LAST     = 4'h7;
  localparam logic [3:0]  RES8_PAD     = 4'h0;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } tsc_state_t;

  typedef enum logic [1:0] {
    MUX_NONE = 2'b00,
    MUX_YP   = 2'b01,
    MUX_XP   = 2'b10
  } tsc_mux_t;

endpackage : tsc_pkg

// [tsc_sync.sv]
/*
  Two-flop synchroniser for a vector of independent levels or toggles.
  Assumes each bit is a level or a toggle, never a multi-bit word.
*/
`timescale 1ns/1ps
module tsc_sync import tsc_pkg::*; #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = d_i;
    next_q    = meta;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= next_meta;
      q_o  <= next_q;
    end
  end

endmodule : tsc_sync

// [tsc_link.sv]
/*
  Serial engine on the host's serial clock: control byte capture on rising
  edges, busy and result shifting on falling edges.
  Assumes the result word is held steady by the system domain and is only
  updated while no result is being loaded.
*/
`timescale 1ns/1ps
module tsc_link import tsc_pkg::*; (
  input  wire logic              sclk_i,
  input  wire logic              rst_b_i,
  input  wire logic              chip_select_n_i,
  input  wire logic              din_i,
  input  wire logic [RES_W-1:0]  result_i,
  output logic      [CTRL_W-1:0] ctrl_o,
  output logic                   ctrl_tog_o,
  output logic                   dout_o,
  output logic                   busy_o
);

  logic              frame_rst_b;
  logic [3:0]        bit_cnt;
  logic [3:0]        next_bit_cnt;
  logic [6:0]        shreg;
  logic [6:0]        next_shreg;
  logic [CTRL_W-1:0] next_ctrl;
  logic              next_ctrl_tog;
  logic              conv_tog;
  logic              next_conv_tog;
  logic              seen_tog;
  logic              next_seen_tog;
  logic              next_busy;
  logic              next_dout;
  logic [RES_W-1:0]  dsh;
  logic [RES_W-1:0]  next_dsh;

  // Frame state clears only on reset or a deselect, so pauses keep it
  assign frame_rst_b = rst_b_i & ~chip_select_n_i;

  always_comb begin
    next_bit_cnt  = bit_cnt;
    next_shreg    = shreg;
    next_ctrl     = ctrl_o;
    next_ctrl_tog = ctrl_tog_o;
    next_conv_tog = conv_tog;
    if (bit_cnt == CNT_HUNT) begin
      if (din_i) begin
        next_bit_cnt = CNT_FIRST;
        next_shreg   = 7'h01;
      end
    end else if (bit_cnt == CNT_LAST) begin
      next_ctrl     = {shreg, din_i};
      next_ctrl_tog = ~ctrl_tog_o;
      next_conv_tog = ~conv_tog;
      next_bit_cnt  = CNT_HUNT;
    end else begin
      next_shreg   = {shreg[5:0], din_i};
      next_bit_cnt = bit_cnt + 4'h1;
    end
  end

  always_ff @(posedge sclk_i or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      bit_cnt  <= CNT_HUNT;
      shreg    <= 7'h00;
      conv_tog <= 1'b0;
    end else begin
      bit_cnt  <= next_bit_cnt;
      shreg    <= next_shreg;
      conv_tog <= next_conv_tog;
    end
  end

  // The toggle must survive deselects, else the system side sees false edges
  always_ff @(posedge sclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_o     <= CTRL_RESET;
      ctrl_tog_o <= 1'b0;
    end else begin
      ctrl_o     <= next_ctrl;
      ctrl_tog_o <= next_ctrl_tog;
    end
  end

  always_comb begin
    next_seen_tog = seen_tog;
    next_busy     = 1'b0;
    next_dout     = dsh[RES_W-1];
    next_dsh      = {dsh[RES_W-2:0], 1'b0};
    if (conv_tog != seen_tog) begin
      next_seen_tog = conv_tog;
      next_busy     = 1'b1;
      next_dout     = 1'b0;
      next_dsh      = dsh;
    end else if (busy_o) begin
      next_dout = result_i[RES_W-1];
      next_dsh  = {result_i[RES_W-2:0], 1'b0};
    end
  end

  always_ff @(negedge sclk_i or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      seen_tog <= 1'b0;
      busy_o   <= 1'b0;
      dout_o   <= 1'b0;
      dsh      <= '0;
    end else begin
      seen_tog <= next_seen_tog;
      busy_o   <= next_busy;
      dout_o   <= next_dout;
      dsh      <= next_dsh;
    end
  end

  a_busy_single: assert property (
    @(negedge sclk_i) disable iff (!frame_rst_b)
    busy_o |=> !busy_o)
    else $error("busy stood longer than one clock");

  a_start_hunt: assert property (
    @(posedge sclk_i) disable iff (!frame_rst_b)
    (bit_cnt == CNT_HUNT && !din_i) |=> bit_cnt == CNT_HUNT)
    else $error("frame began without a start bit");

endmodule : tsc_link

// [tsc_top.sv]
/*
  Touch-screen converter control: serial control byte decode, plate driver
  and reference routing, power sequencing, pen interrupt, result shifting.
  Assumes an analog core on clk_i that converts on conv_start_o and returns
  the code with a one-cycle adc_done_i, fast enough to finish before the
  host's next serial clock after busy.
*/
// Function
// - Ignore input until a high start bit
// - 24 clocks: byte, busy, 12 bits, zeros
// - Mode bit one selects 8-bit results
// - Data and busy float while deselected
// - Reference bit one selects single-ended reference
// - Power-down codes set power and pen interrupt
// - Next byte may overlap, conversion every 16
// - Stay powered and keep state across pauses
// - 8-bit result ends four clocks earlier
// - Differential reference ties to driven plates
// - Code 101 routes Y+ with X drivers
// - Code 001 routes X+ with Y drivers
// - Pen output pulls low while touched
// - Pen detect on in sleep code 00 only, no wake delay
`timescale 1ns/1ps
module tsc_top import tsc_pkg::*; (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             ce_i,
  input  wire logic             serial_clock_in_i,
  input  wire logic             chip_select_n_i,
  input  wire logic             serial_data_in_i,
  output logic                  serial_data_out_o,
  output logic                  serial_data_out_oe_o,
  output logic                  busy_o,
  output logic                  busy_oe_o,
  output logic                  touch_irq_n_o,
  output logic                  touch_irq_n_oe_o,
  input  wire logic             touch_sense_i,
  input  wire logic [RES_W-1:0] adc_code_i,
  input  wire logic             adc_done_i,
  output logic                  conv_start_o,
  output tsc_mux_t              adc_in_sel_o,
  output logic                  x_drv_o,
  output logic                  y_drv_o,
  output logic                  ref_diff_o,
  output logic                  res8_o,
  output logic                  analog_power_o
);

  logic [CTRL_W-1:0] link_ctrl;
  logic              link_ctrl_tog;
  logic              link_dout;
  logic              link_busy;
  logic [1:0]        sync_in;
  logic [1:0]        sync_out;
  logic              tog_s;
  logic              touch_s;
  logic              tog_d;
  logic              next_tog_d;
  logic              new_ctrl;

  tsc_state_t        state;
  tsc_state_t        next_state;
  logic [CTRL_W-1:0] ctrl_app;
  logic [CTRL_W-1:0] next_ctrl_app;
  logic              next_conv_start;
  tsc_mux_t          next_sel;
  logic              next_x_drv;
  logic              next_y_drv;
  logic              next_ref_diff;
  logic              next_res8;
  logic              next_power;
  logic [RES_W-1:0]  result;
  logic [RES_W-1:0]  next_result;

  logic [2:0]        sel_code;
  logic [1:0]        pd_code;
  logic              pen_enable;
  logic              next_irq_oe;
  logic              next_irq_n;

  tsc_link u_link (
    .sclk_i          (serial_clock_in_i),
    .rst_b_i         (rst_b_i),
    .chip_select_n_i (chip_select_n_i),
    .din_i           (serial_data_in_i),
    .result_i        (result),
    .ctrl_o          (link_ctrl),
    .ctrl_tog_o      (link_ctrl_tog),
    .dout_o          (link_dout),
    .busy_o          (link_busy)
  );

  assign sync_in = {touch_sense_i, link_ctrl_tog};

  tsc_sync #(.W(2)) u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (sync_in),
    .q_o     (sync_out)
  );

  assign tog_s   = sync_out[0];
  assign touch_s = sync_out[1];

  // The pins float on the select level itself; a flop would need a clock
  // that a deselected host does not supply
  assign serial_data_out_o    = link_dout;
  assign busy_o               = link_busy;
  assign serial_data_out_oe_o = ~chip_select_n_i;
  assign busy_oe_o            = ~chip_select_n_i;

  // The link holds its control byte steady from one toggle to the next,
  // so it is safe to read once the synchronised toggle has moved
  assign new_ctrl = tog_s ^ tog_d;
  assign sel_code = link_ctrl[BIT_SEL_HI:BIT_SEL_LO];

  always_comb begin
    next_tog_d      = tog_d;
    next_state      = state;
    next_ctrl_app   = ctrl_app;
    next_conv_start = 1'b0;
    next_sel        = adc_in_sel_o;
    next_x_drv      = x_drv_o;
    next_y_drv      = y_drv_o;
    next_ref_diff   = ref_diff_o;
    next_res8       = res8_o;
    next_power      = analog_power_o;
    next_result     = result;
    if (!ce_i) begin
      next_conv_start = conv_start_o;
    end else if (new_ctrl) begin
      next_tog_d      = tog_s;
      next_ctrl_app   = link_ctrl;
      next_state      = ST_CONV;
      next_conv_start = 1'b1;
      next_power      = 1'b1;
      next_res8       = link_ctrl[BIT_MODE];
      next_ref_diff   = ~link_ctrl[BIT_REF];
      unique case (sel_code)
        SEL_XPOS: begin
          next_sel   = MUX_YP;
          next_x_drv = 1'b1;
          next_y_drv = 1'b0;
        end
        SEL_YPOS: begin
          next_sel   = MUX_XP;
          next_x_drv = 1'b0;
          next_y_drv = 1'b1;
        end
        default: begin
          next_sel   = MUX_NONE;
          next_x_drv = 1'b0;
          next_y_drv = 1'b0;
        end
      endcase
    end else begin
      unique case (state)
        ST_IDLE: begin
          next_power = (ctrl_app[BIT_PD_HI:BIT_PD_LO] == PD_ALWAYS_ON);
        end
        ST_CONV: begin
          // Single-ended holds the sample, so the plates may drop early;
          // ratiometric keeps them on because they are the reference
          if (ctrl_app[BIT_REF]) begin
            next_x_drv = 1'b0;
            next_y_drv = 1'b0;
          end
          if (adc_done_i) begin
            next_state = ST_IDLE;
            next_x_drv = 1'b0;
            next_y_drv = 1'b0;
            next_sel   = MUX_NONE;
            if (ctrl_app[BIT_MODE]) begin
              next_result = {adc_code_i[RES_W-1:RES_W-RES8_W],
                             RES8_PAD};
            end else begin
              next_result = adc_code_i;
            end
            next_power = (ctrl_app[BIT_PD_HI:BIT_PD_LO]
                          == PD_ALWAYS_ON);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tog_d          <= 1'b0;
      state          <= ST_IDLE;
      ctrl_app       <= CTRL_RESET;
      conv_start_o   <= 1'b0;
      adc_in_sel_o   <= MUX_NONE;
      x_drv_o        <= 1'b0;
      y_drv_o        <= 1'b0;
      ref_diff_o     <= 1'b0;
      res8_o         <= 1'b0;
      analog_power_o <= 1'b0;
      result         <= '0;
    end else begin
      tog_d          <= next_tog_d;
      state          <= next_state;
      ctrl_app       <= next_ctrl_app;
      conv_start_o   <= next_conv_start;
      adc_in_sel_o   <= next_sel;
      x_drv_o        <= next_x_drv;
      y_drv_o        <= next_y_drv;
      ref_diff_o     <= next_ref_diff;
      res8_o         <= next_res8;
      analog_power_o <= next_power;
      result         <= next_result;
    end
  end

  // Pen detect only between conversions: driven plates would fake a touch
  assign pd_code    = ctrl_app[BIT_PD_HI:BIT_PD_LO];
  assign pen_enable = (pd_code == PD_SLEEP_IRQ) && (state == ST_IDLE);

  always_comb begin
    next_irq_oe = touch_irq_n_oe_o;
    next_irq_n  = touch_irq_n_o;
    if (ce_i) begin
      next_irq_oe = pen_enable && touch_s;
      next_irq_n  = ~(pen_enable && touch_s);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      touch_irq_n_oe_o <= 1'b0;
      touch_irq_n_o    <= 1'b1;
    end else begin
      touch_irq_n_oe_o <= next_irq_oe;
      touch_irq_n_o    <= next_irq_n;
    end
  end

  a_xpos_route: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && new_ctrl && sel_code == SEL_XPOS)
    |=> (adc_in_sel_o == MUX_YP) && x_drv_o && !y_drv_o)
    else $error("code 101 routing wrong");

  a_ypos_route: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && new_ctrl && sel_code == SEL_YPOS)
    |=> (adc_in_sel_o == MUX_XP) && !x_drv_o && y_drv_o)
    else $error("code 001 routing wrong");

  a_ref_mode: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && new_ctrl)
    |=> ref_diff_o == !$past(link_ctrl[BIT_REF]))
    else $error("reference mode not taken from control byte");

  a_mode_take: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && new_ctrl)
    |=> res8_o == $past(link_ctrl[BIT_MODE]))
    else $error("resolution not taken from control byte");

  a_no_wake: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && new_ctrl) |=> conv_start_o && analog_power_o)
    else $error("conversion start delayed by power-up");

  a_start_pulse: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && conv_start_o && !new_ctrl) |=> !conv_start_o)
    else $error("conversion start stood longer than one cycle");

  // Single-ended holds its sample, so the plates must not stay loaded
  a_single_drop: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && !new_ctrl && state == ST_CONV && ctrl_app[BIT_REF])
    |=> !x_drv_o && !y_drv_o)
    else $error("plate drivers kept on in single-ended mode");

  a_ratio_hold: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && !new_ctrl && state == ST_CONV && !ctrl_app[BIT_REF]
     && !adc_done_i)
    |=> $stable({x_drv_o, y_drv_o}))
    else $error("plate drivers dropped during ratiometric conversion");

  a_done_release: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && !new_ctrl && state == ST_CONV && adc_done_i)
    |=> adc_in_sel_o == MUX_NONE && !x_drv_o && !y_drv_o)
    else $error("plates still driven after conversion");

  a_res12_full: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && !new_ctrl && state == ST_CONV && adc_done_i
     && !ctrl_app[BIT_MODE])
    |=> result == $past(adc_code_i))
    else $error("12-bit result not taken whole");

  a_pen_low: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && pen_enable && touch_s)
    |=> touch_irq_n_oe_o && !touch_irq_n_o)
    else $error("touch not signalled");

  a_pen_masked: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (pd_code == PD_SLEEP_NOIRQ) [*2] |-> !touch_irq_n_oe_o)
    else $error("pen output active with detection off");

  a_power_hold: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && state == ST_IDLE && !new_ctrl && pd_code == PD_ALWAYS_ON)
    |=> analog_power_o)
    else $error("powered down despite always-on code");

  a_res8_pad: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && !new_ctrl && state == ST_CONV && adc_done_i
     && ctrl_app[BIT_MODE])
    |=> result[RES_W-RES8_W-1:0] == RES8_PAD
        && result[RES_W-1:RES_W-RES8_W]
           == $past(adc_code_i[RES_W-1:RES_W-RES8_W]))
    else $error("8-bit result not packed");

endmodule : tsc_top

// [tsc_host.sv]
/*
  Host serial port model: chip select, serial clock and data in bursts.
  Assumes the bench pauses between bursts while a conversion runs.
*/
`timescale 1ns/1ps
module tsc_host (
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      din_o,
  input  wire logic dout_i,
  input  wire logic busy_i
);
  logic [63:0] dhist;
  logic [63:0] bhist;

  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o  = 1'b0;
    dhist  = '0;
    bhist  = '0;
  end

  task automatic select();
    cs_n_o = 1'b0;
    dhist  = '0;
    bhist  = '0;
    #20;
  endtask : select

  // Released data line flips so a stale level never looks like valid data
  task automatic deselect();
    cs_n_o = 1'b1;
    din_o  = ~din_o;
    #20;
  endtask : deselect

  // Clock runs only inside bursts; data changes after each falling edge
  task automatic xfer(input int n,
                      input logic [15:0] bits);
    for (int i = n - 1; i >= 0; i--) begin
      din_o = bits[i];
      #6 sclk_o = 1'b1;
      dhist = {dhist[62:0], dout_i};
      bhist = {bhist[62:0], busy_i};
      #6 sclk_o = 1'b0;
    end
  endtask : xfer
endmodule : tsc_host

// [tsc_top_tb.sv]
/*
  Self-checking bench for the touch-screen converter control block.
  Assumes the host model in tsc_host.sv; the analog core is modelled here.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tsc_top_tb import tsc_pkg::*;;
  logic             clk_i;
  logic             rst_b_i;
  logic             ce_i;
  logic             touch_sense_i;
  logic [RES_W-1:0] adc_code_i;
  logic             adc_done_i;
  wire              sclk;
  wire              cs_n;
  wire              din;
  logic             serial_data_out_o;
  logic             serial_data_out_oe_o;
  logic             busy_o;
  logic             busy_oe_o;
  logic             touch_irq_n_o;
  logic             touch_irq_n_oe_o;
  logic             conv_start_o;
  tsc_mux_t         adc_in_sel_o;
  logic             x_drv_o;
  logic             y_drv_o;
  logic             ref_diff_o;
  logic             res8_o;
  logic             analog_power_o;
  int               num_errors = 0;
  int               n_checks = 0;
  int               n_done = 0;
  int               n_conv = 0;
  int               dly = 0;
  logic [15:0]      lfsr = 16'h004B;
  logic [7:0]       cur;
  logic [7:0]       ctrls[$];
  logic [11:0]      codes[$];
  // Pull-up on the touch line; floating serial outputs read as high impedance (z)
  wire dout_w = serial_data_out_oe_o ? serial_data_out_o : 1'bz;
  wire busy_w = busy_oe_o ? busy_o : 1'bz;
  wire irq_w  = touch_irq_n_oe_o ? touch_irq_n_o : 1'b1;

  tsc_top uut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .serial_clock_in_i(sclk), .chip_select_n_i(cs_n),
    .serial_data_in_i(din), .serial_data_out_o(serial_data_out_o),
    .serial_data_out_oe_o(serial_data_out_oe_o), .busy_o(busy_o),
    .busy_oe_o(busy_oe_o), .touch_irq_n_o(touch_irq_n_o),
    .touch_irq_n_oe_o(touch_irq_n_oe_o), .touch_sense_i(touch_sense_i),
    .adc_code_i(adc_code_i), .adc_done_i(adc_done_i),
    .conv_start_o(conv_start_o), .adc_in_sel_o(adc_in_sel_o),
    .x_drv_o(x_drv_o), .y_drv_o(y_drv_o), .ref_diff_o(ref_diff_o),
    .res8_o(res8_o), .analog_power_o(analog_power_o)
  );

  tsc_host host (
    .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din),
    .dout_i(dout_w), .busy_i(busy_w)
  );

  initial clk_i = 1'b0;
  always #25 clk_i = ~clk_i;

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr_next

  function automatic logic [1:0] pd_of(input int k);
    return (k % 3 == 0) ? PD_ALWAYS_ON :
           (k % 3 == 1) ? PD_SLEEP_NOIRQ : PD_SLEEP_IRQ;
  endfunction : pd_of

  function automatic tsc_mux_t exp_sel(input logic [7:0] c);
    return (c[6:4] == SEL_XPOS) ? MUX_YP : MUX_XP;
  endfunction : exp_sel

  function automatic logic [1:0] exp_drv(input logic [7:0] c);
    return (c[6:4] == SEL_XPOS) ? 2'h2 : 2'h1;
  endfunction : exp_drv

  // Analog core: answers three cycles after each start with a random code
  always @(negedge clk_i) begin : analog_core
    logic dn;
    dn = 1'b0;
    if (dly > 0) begin
      dly--;
      if (dly == 0) begin
        lfsr = lfsr_next(lfsr);
        adc_code_i = lfsr[11:0];
        codes.push_back(lfsr[11:0]);
        dn = 1'b1;
        n_done++;
        `CHK({x_drv_o, y_drv_o},
             cur[BIT_REF] ? 2'h0 : exp_drv(cur))
      end
    end
    if (conv_start_o === 1'b1) begin
      cur = ctrls.pop_front();
      dly = 3;
      n_conv++;
      `CHK(adc_in_sel_o, exp_sel(cur))
      `CHK({x_drv_o, y_drv_o}, exp_drv(cur))
      `CHK({ref_diff_o, res8_o},
           {~cur[BIT_REF], cur[BIT_MODE]})
      `CHK(analog_power_o, 1'b1)
    end
    adc_done_i = dn;
  end

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  task automatic wait_conv();
    int k0;
    k0 = n_done;
    for (int i = 0; i < 60 && n_done == k0; i++) @(posedge clk_i);
    `CHK(n_done, k0 + 1)
    repeat (3) @(posedge clk_i);
  endtask : wait_conv

  // Two overlapped frames; host pauses after each byte for the conversion
  task automatic run_pair(input logic [7:0] c1, input logic [7:0] c2);
    int          s;
    int          t;
    int          w;
    logic [63:0] got;
    logic [63:0] ex;
    w = c1[BIT_MODE] ? RES8_W : RES_W;
    s = w + 4;
    t = 2 * s + 8;
    host.select();
    `CHK({serial_data_out_oe_o, busy_oe_o}, 2'h3)
    ctrls.push_back(c1);
    host.xfer(8, {8'h00, c1});
    wait_conv();
    host.xfer(s - 8, 16'h0000);
    ctrls.push_back(c2);
    host.xfer(8, {8'h00, c2});
    wait_conv();
    host.xfer(s, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      got = (host.dhist >> (t - (k * s + w + 12))) & ((64'h1 << (w + 3)) - 1);
      ex = (64'(codes.pop_front()) >> (12 - w)) << 3;
      `CHK(got, ex)
    end
    ex = (64'h1 << (t - 9)) | (64'h1 << (t - 9 - s));
    `CHK(host.bhist & ((64'h1 << t) - 1), ex)
    host.deselect();
    `CHK({serial_data_out_oe_o, busy_oe_o}, 2'h0)
  endtask : run_pair

  task automatic pen_check(input logic [1:0] pd);
    // A touch while frozen must not reach the pin until the enable returns
    @(negedge clk_i) begin
      ce_i = 1'b0;
      touch_sense_i = 1'b1;
    end
    repeat (6) @(negedge clk_i);
    `CHK(irq_w, 1'b1)
    ce_i = 1'b1;
    repeat (6) @(negedge clk_i);
    `CHK(irq_w, pd != PD_SLEEP_IRQ)
    `CHK(analog_power_o, pd == PD_ALWAYS_ON)
    touch_sense_i = 1'b0;
    repeat (6) @(negedge clk_i);
    `CHK(irq_w, 1'b1)
  endtask : pen_check

  // About 320 cycles are needed; the margin covers slow handshakes
  initial begin
    repeat (4000) @(posedge clk_i);
    num_errors++;
    wrap_up();
  end

  initial begin
    logic [7:0] c1;
    logic [7:0] c2;
    rst_b_i = 1'b0;
    ce_i = 1'b1;
    touch_sense_i = 1'b0;
    adc_code_i = '0;
    adc_done_i = 1'b0;
    repeat (20) @(negedge clk_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge clk_i);
    `CHK({serial_data_out_oe_o, busy_oe_o, irq_w}, 3'h1)
    // Zeros while hunting, then a byte cut short by deselect
    host.select();
    host.xfer(8, 16'h0000);
    host.xfer(5, 16'h0015);
    host.deselect();
    repeat (10) @(negedge clk_i);
    `CHK(n_conv, 0)
    $display("test hunt_abort done errors=%0d", num_errors);
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      // Only legal channel and power codes are issued
      c1 = {1'b1, i[0] ? SEL_XPOS : SEL_YPOS, i[1], i[0] ^ i[1],
            pd_of(int'(lfsr[3:0]))};
      c2 = {1'b1, lfsr[8] ? SEL_XPOS : SEL_YPOS, i[1], lfsr[9],
            pd_of(i)};
      run_pair(c1, c2);
      pen_check(c2[1:0]);
      $display("test pair %0d done errors=%0d", i, num_errors);
    end
    wrap_up();
  end
endmodule : tsc_top_tb
